/* core/pixel_path_regs.vh */
`ifndef PIXEL_PATH_REGS_VH
`define PIXEL_PATH_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_CURMAP 8'h08
`define A_PMAP 8'h0c
// ----------------------------------------
// Control fields
// ----------------------------------------
`define C_EXPR 0
`define C_DITH 1
`define C_ALPHA 2
`define C_ADBL 3
`define C_PUPEN 4
`define C_WIDE 5
`define C_VOUT 6
`define CTRL_RST 7'h22
// ----------------------------------------
// Mode word fields
// ----------------------------------------
`define M_TAG 1:0
`define M_VID 2
`define M_AUXEN 3
`define M_CIMSB 8:4
`define M_AUXMSB 13:9
// ----------------------------------------
// Encodings and sizes
// ----------------------------------------
`define TAG_CI 2'h0
`define SEL_ADDR 3'h0
`define SEL_DATA 3'h1
`define SEL_CUR 3'h2
`define SEL_PUP 3'h3
`define PIPE_N 5
`define ALPHA_DLY 4
`define FIFO_D 8
`define FIFO_AW 3
`define SPLIT_OUT 24'hf0f0f0
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

/* core/pixel_path_select_video.v */
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "pixel_path_regs.vh"
module pixel_path_select_video (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [23:0] pix_in,
    input  wire [7:0]  aux_in,
    input  wire [1:0]  pup_in,
    input  wire [1:0]  cur_in,
    input  wire [4:0]  did_in,
    input  wire        c_blank_n,
    output reg  [23:0] pix_out,
    output reg  [1:0]  pix_tag,
    input  wire [23:0] map_rgb,
    output wire        quarter_pixel_clock,
    input  wire [23:0] vid_in,
    output reg  [23:0] vid_out,
    output wire [23:0] vid_out_en,
    output wire        vid_oe,
    output wire        vid_alpha,
    input  wire        video_key,
    input  wire [7:0]  host_command_bus,
    input  wire [2:0]  host_register_select,
    input  wire        host_cs_n,
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output wire        awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output wire        wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output wire        arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready
);
// ----------------------------------------
// Control register and bus slave
// ----------------------------------------
reg  [6:0]  ctrl_r;
reg         ovf_r;
reg  [7:0]  cur_map_r;
reg  [7:0]  pup_map_r;
reg  [7:0]  aw_r;
reg         aw_ok_r;
reg  [31:0] w_r;
reg  [3:0]  ws_r;
reg         w_ok_r;
reg  [`FIFO_AW:0] fcnt_r;
reg         phase_r;
wire        fifo_full;
wire        ovf_set;
wire        do_wr;
assign awready = !aw_ok_r && !bvalid;
assign wready  = !w_ok_r && !bvalid;
assign arready = !rvalid;
assign do_wr   = aw_ok_r && w_ok_r && !bvalid;
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        aw_r    <= 8'h00;
        aw_ok_r <= 1'b0;
        w_r     <= 32'h00000000;
        ws_r    <= 4'h0;
        w_ok_r  <= 1'b0;
        bvalid  <= 1'b0;
        bresp   <= `RESP_OK;
        ctrl_r  <= `CTRL_RST;
        ovf_r   <= 1'b0;
    end else begin
        if (awvalid && awready) begin
            aw_r    <= awaddr;
            aw_ok_r <= 1'b1;
        end
        if (wvalid && wready) begin
            w_r    <= wdata;
            ws_r   <= wstrb;
            w_ok_r <= 1'b1;
        end
        if (do_wr) begin
            aw_ok_r <= 1'b0;
            w_ok_r  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (aw_r == `A_CTRL || aw_r == `A_STAT) ? `RESP_OK : `RESP_ERR;
            if (aw_r == `A_CTRL && ws_r[0])
                ctrl_r <= w_r[6:0];
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
        if (ovf_set)
            ovf_r <= 1'b1;
        else if (do_wr && aw_r == `A_STAT && ws_r[0] && w_r[0])
            ovf_r <= 1'b0;
    end
end
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        rvalid <= 1'b0;
        rdata  <= 32'h00000000;
        rresp  <= `RESP_OK;
    end else if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OK;
        case (araddr)
            `A_CTRL: rdata <= {25'h0, ctrl_r};
            `A_STAT: rdata <= {24'h0, !c_blank_n, phase_r, fcnt_r, fifo_full, ovf_r};
            `A_CURMAP: rdata <= {24'h0, cur_map_r};
            `A_PMAP: rdata <= {24'h0, pup_map_r};
            default: begin
                rdata <= 32'h00000000;
                rresp <= `RESP_ERR;
            end
        endcase
    end else if (rvalid && rready) begin
        rvalid <= 1'b0;
    end
end
// ----------------------------------------
// Host command bus capture
// ----------------------------------------
reg        cs_s1_r;
reg        cs_s2_r;
reg        cs_s3_r;
reg  [7:0] hdat_r;
reg  [2:0] hsel_r;
wire       cs_go;
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        cs_s1_r <= 1'b0;
        cs_s2_r <= 1'b0;
        cs_s3_r <= 1'b0;
    end else begin
        cs_s1_r <= !host_cs_n;
        cs_s2_r <= cs_s1_r;
        cs_s3_r <= cs_s2_r;
    end
end
assign cs_go = cs_s2_r && !cs_s3_r;
// Hold bus while strobe is seen, sample on falling clock edge
always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        hdat_r <= 8'h00;
        hsel_r <= 3'h0;
    end else if (!cs_s2_r) begin
        hdat_r <= host_command_bus;
        hsel_r <= host_register_select;
    end
end
// ----------------------------------------
// Mode word packing and FIFO
// ----------------------------------------
reg  [4:0]  pk_adr_r;
reg  [15:0] pk_dat_r;
reg  [1:0]  pk_cnt_r;
reg  [28:0] fifo_m [0:`FIFO_D-1];
reg  [`FIFO_AW-1:0] wp_r;
reg  [`FIFO_AW-1:0] rp_r;
reg  [23:0] mode_ram [0:31];
wire        push;
wire        pop;
wire [28:0] fhead;
assign push      = cs_go && hsel_r == `SEL_DATA && pk_cnt_r == 2'h2 && !fifo_full;
assign ovf_set   = cs_go && hsel_r == `SEL_DATA && pk_cnt_r == 2'h2 && fifo_full;
assign fifo_full = fcnt_r == `FIFO_D;
assign pop       = !c_blank_n && fcnt_r != 0;
assign fhead     = fifo_m[rp_r];
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        pk_adr_r  <= 5'h00;
        pk_dat_r  <= 16'h0000;
        pk_cnt_r  <= 2'h0;
        cur_map_r <= 8'h00;
        pup_map_r <= 8'h00;
        wp_r      <= {`FIFO_AW{1'b0}};
        rp_r      <= {`FIFO_AW{1'b0}};
        fcnt_r    <= {(`FIFO_AW+1){1'b0}};
    end else begin
        if (cs_go) begin
            case (hsel_r)
                `SEL_ADDR: begin
                    pk_adr_r <= hdat_r[4:0];
                    pk_cnt_r <= 2'h0;
                end
                `SEL_DATA: begin
                    pk_dat_r <= {pk_dat_r[7:0], hdat_r};
                    pk_cnt_r <= (pk_cnt_r == 2'h2) ? 2'h0 : pk_cnt_r + 2'h1;
                end
                `SEL_CUR: cur_map_r <= hdat_r;
                `SEL_PUP: pup_map_r <= hdat_r;
                default: pk_cnt_r <= pk_cnt_r;
            endcase
        end
        if (push) begin
            fifo_m[wp_r] <= {pk_adr_r, pk_dat_r, hdat_r};
            wp_r         <= wp_r + 1'b1;
        end
        if (pop)
            rp_r <= rp_r + 1'b1;
        if (push && !pop)
            fcnt_r <= fcnt_r + 1'b1;
        else if (pop && !push)
            fcnt_r <= fcnt_r - 1'b1;
    end
end
always @(posedge clk_sys) begin
    if (pop)
        mode_ram[fhead[28:24]] <= fhead[23:0];
end
// ----------------------------------------
// Pixel pipeline to colour map
// ----------------------------------------
reg  [41:0] pp_r [0:2];
reg  [23:0] vd_r [0:2];
reg  [23:0] md_r;
reg  [41:0] s3_r;
reg  [23:0] v3_r;
wire [41:0] pp_in;
wire [23:0] pp_pix;
wire [7:0]  pp_aux;
wire [1:0]  pp_pup;
wire [1:0]  pp_cur;
wire        pp_key;
reg  [23:0] sel_pix;
reg  [1:0]  sel_tag;
integer     k;
integer     j;
assign pp_in  = {video_key, cur_in, did_in, pup_in, aux_in, pix_in};
assign pp_pix = s3_r[23:0];
assign pp_aux = ctrl_r[`C_WIDE] ? s3_r[31:24] : {6'h00, s3_r[25:24]};
assign pp_pup = s3_r[33:32];
assign pp_cur = s3_r[40:39];
assign pp_key = s3_r[41];
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        for (k = 0; k < 3; k = k + 1) begin
            pp_r[k] <= 42'h0;
            vd_r[k] <= 24'h000000;
        end
        s3_r    <= 42'h0;
        v3_r    <= 24'h000000;
        md_r    <= 24'h000000;
        pix_out <= 24'h000000;
        pix_tag <= `TAG_CI;
    end else begin
        pp_r[0] <= pp_in;
        vd_r[0] <= vid_in;
        for (k = 1; k < 3; k = k + 1) begin
            pp_r[k] <= pp_r[k-1];
            vd_r[k] <= vd_r[k-1];
        end
        md_r    <= mode_ram[pp_r[2][38:34]];
        s3_r    <= pp_r[2];
        v3_r    <= vd_r[2];
        pix_out <= sel_pix;
        pix_tag <= sel_tag;
    end
end
always @* begin
    sel_tag = `TAG_CI;
    sel_pix = 24'h000000;
    if (pp_cur != 2'h0) begin
        sel_pix = {11'h000, cur_map_r, 3'h0, pp_cur};
    end else if (ctrl_r[`C_PUPEN] && pp_pup != 2'h0) begin
        sel_pix = {11'h000, pup_map_r, 3'h0, pp_pup};
    end else if (md_r[`M_AUXEN] && pp_aux != 8'h00) begin
        sel_pix = {11'h000, md_r[`M_AUXMSB], pp_aux};
    end else if (md_r[`M_VID] && pp_key) begin
        sel_tag = md_r[`M_TAG];
        if (ctrl_r[`C_EXPR])
            sel_pix = v3_r;
        else
            sel_pix = {v3_r[19:16], v3_r[19:16], v3_r[11:8], v3_r[11:8], v3_r[3:0], v3_r[3:0]};
    end else begin
        sel_tag = md_r[`M_TAG];
        if (md_r[`M_TAG] == `TAG_CI)
            sel_pix = {11'h000, md_r[`M_CIMSB], pp_pix[7:0]};
        else
            sel_pix = pp_pix;
    end
end
// ----------------------------------------
// Half-rate phase and dither position
// ----------------------------------------
reg        blank_d_r;
reg  [1:0] dx_r;
reg  [1:0] dy_r;
wire       blank_rise;
assign blank_rise          = c_blank_n && !blank_d_r;
assign quarter_pixel_clock = phase_r;
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        blank_d_r <= 1'b0;
        phase_r   <= 1'b0;
        dx_r      <= 2'h0;
        dy_r      <= 2'h0;
    end else begin
        blank_d_r <= c_blank_n;
        phase_r   <= blank_rise ? 1'b0 : !phase_r;
        if (blank_rise) begin
            dx_r <= 2'h0;
            dy_r <= dy_r + 2'h1;
        end else begin
            dx_r <= dx_r + 2'h1;
        end
    end
end
// ----------------------------------------
// Video select toward the board
// ----------------------------------------
reg  [23:0] rgb_r;
reg  [7:0]  al_r [0:`ALPHA_DLY-1];
reg  [23:0] vsel;
wire [3:0]  thr;
wire [11:0] dith;
wire [7:0]  al;
wire [3:0]  an;
assign thr = {dx_r[0] ^ dy_r[0], dy_r[0], dx_r[1] ^ dy_r[1], dy_r[1]};
assign al  = al_r[`ALPHA_DLY-1];
assign an  = al[7:4];
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : dth
        wire [8:0] sum = {1'b0, rgb_r[8*g+7:8*g]} + {5'h00, thr};
        assign dith[4*g+3:4*g] = sum[8] ? 4'hf : sum[7:4];
    end
endgenerate
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        rgb_r <= 24'h000000;
        for (j = 0; j < `ALPHA_DLY; j = j + 1)
            al_r[j] <= 8'h00;
        vid_out <= 24'h000000;
    end else begin
        rgb_r   <= map_rgb;
        al_r[0] <= pp_aux;
        for (j = 1; j < `ALPHA_DLY; j = j + 1)
            al_r[j] <= al_r[j-1];
        vid_out <= vsel;
    end
end
always @* begin
    if (!ctrl_r[`C_EXPR]) begin
        if (ctrl_r[`C_DITH])
            vsel = {dith[11:8], 4'h0, dith[7:4], 4'h0, dith[3:0], 4'h0};
        else
            vsel = {rgb_r[23:20], 4'h0, rgb_r[15:12], 4'h0, rgb_r[7:4], 4'h0};
    end else if (!ctrl_r[`C_ALPHA]) begin
        vsel = rgb_r;
    end else if (!ctrl_r[`C_ADBL]) begin
        vsel = {rgb_r[23:19], al[7:5], rgb_r[15:10], al[4:3], rgb_r[7:3], al[2:0]};
    end else begin
        vsel = {rgb_r[23:19], an[3:1], rgb_r[15:10], an[0], an[3], rgb_r[7:3], an[2:0]};
    end
end
assign vid_oe     = ctrl_r[`C_EXPR] && ctrl_r[`C_VOUT];
assign vid_out_en = ctrl_r[`C_EXPR] ? {24{vid_oe}} : `SPLIT_OUT;
assign vid_alpha  = vid_oe && ctrl_r[`C_ALPHA];
endmodule
`default_nettype wire

/* tb/far_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [23:0] pix_out,
    input wire logic [1:0]  pix_tag,
    input wire logic [23:0] vid_out,
    input wire logic [23:0] vid_out_en,
    output logic     [23:0] map_rgb,
    output logic     [23:0] vid_in
);
    logic [23:0] board_r;
    // ----------------------------------------
    // Colour map lookup and board pattern
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            map_rgb <= 24'h0;
            board_r <= 24'h0;
        end else begin
            map_rgb <= {pix_out[7:0], pix_out[15:8], pix_out[23:16]} ^ {22'h0, pix_tag};
            board_r <= board_r + 24'h010203;
        end
    end
    // Enabled lines carry device data, others the board's changing pattern
    assign vid_in = (vid_out & vid_out_en) | (board_r & ~vid_out_en);
endmodule
`default_nettype wire

/* tb/pixel_path_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module pixel_path_properties (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [1:0]  cur_in,
    input wire logic        c_blank_n,
    input wire logic [23:0] pix_out,
    input wire logic [1:0]  pix_tag,
    input wire logic [23:0] map_rgb,
    input wire logic        quarter_pixel_clock,
    input wire logic [23:0] vid_out,
    input wire logic [23:0] vid_out_en,
    input wire logic        vid_oe,
    input wire logic        vid_alpha
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Pixel path
    // ----------------------------------------
    cursor_format_a: assert property (
        cur_in != 2'h0 |-> ##5 pix_tag == 2'h0 && pix_out[1:0] == $past(cur_in, 5) && pix_out[4:2] == 3'h0)
        else $error("cursor pixel format");
    index_upper_a: assert property (
        pix_tag == 2'h0 |-> pix_out[23:13] == 11'h0)
        else $error("index upper bits");
    // ----------------------------------------
    // Video link
    // ----------------------------------------
    qclk_align_a: assert property (
        $past(nrst) && $rose(c_blank_n) |=> !quarter_pixel_clock)
        else $error("quarter clock phase");
    qclk_toggle_a: assert property (
        $past(nrst) && !$rose(c_blank_n) |=> quarter_pixel_clock == !$past(quarter_pixel_clock))
        else $error("quarter clock toggle");
    express_pass_a: assert property (
        (vid_oe && !vid_alpha) [*3] |-> vid_out == $past(map_rgb, 2))
        else $error("full video word");
    alpha_merge_a: assert property (
        (vid_oe && vid_alpha) [*3] |-> (vid_out & 24'hf8fcf8) == ($past(map_rgb, 2) & 24'hf8fcf8))
        else $error("alpha merge");
    split_nibble_a: assert property (
        (vid_out_en == 24'hf0f0f0) [*2] |-> (vid_out & 24'h0f0f0f) == 24'h0)
        else $error("split low nibbles");
    oe_full_a: assert property (
        vid_oe |-> vid_out_en == 24'hffffff)
        else $error("full bus enables");
    cover property (cur_in != 2'h0 ##5 pix_tag == 2'h0);
    cover property (vid_oe && vid_alpha);
    cover property ($rose(c_blank_n));
endmodule
bind pixel_path_select_video pixel_path_properties chk (
    .clk_sys, .nrst, .cur_in, .c_blank_n, .pix_out, .pix_tag, .map_rgb,
    .quarter_pixel_clock, .vid_out, .vid_out_en, .vid_oe, .vid_alpha
);
`default_nettype wire

/* tb/pixel_path_select_video_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pixel_path_regs.vh"
module pixel_path_select_video_bench;
    logic        clk_sys, nrst, c_blank_n, video_key, host_cs_n, awvalid, wvalid, bready, arvalid, rready;
    logic [23:0] pix_in;
    logic [7:0]  aux_in, host_command_bus, awaddr, araddr;
    logic [1:0]  pup_in, cur_in, rsp;
    logic [4:0]  did_in;
    logic [2:0]  host_register_select;
    logic [31:0] wdata, rd_data;
    logic [3:0]  wstrb;
    wire  [23:0] pix_out, map_rgb, vid_in, vid_out, vid_out_en;
    wire  [1:0]  pix_tag, bresp, rresp;
    wire  [31:0] rdata;
    wire         quarter_pixel_clock, vid_oe, vid_alpha, awready, wready, bvalid, arready, rvalid;
    int          bad_count, checks_done;
    pixel_path_select_video uut (
        .clk_sys, .nrst, .pix_in, .aux_in, .pup_in, .cur_in, .did_in, .c_blank_n, .pix_out, .pix_tag,
        .map_rgb, .quarter_pixel_clock, .vid_in, .vid_out, .vid_out_en, .vid_oe, .vid_alpha, .video_key,
        .host_command_bus, .host_register_select, .host_cs_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );
    far_side_model far (
        .clk_sys, .nrst, .pix_out, .pix_tag, .vid_out, .vid_out_en, .map_rgb, .vid_in
    );
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, td;
        @(posedge clk_sys);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        n = 0;
        td = 1'b0;
        while (!td && n < 40) begin
            @(negedge clk_sys);
            ta = wr ? awready : arready;
            tw = wready;
            td = wr ? bvalid : rvalid;
            rsp = wr ? bresp : rresp;
            rd_data = rdata;
            @(posedge clk_sys);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (tw)
                wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (!td) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task host_byte(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_sys);
        host_register_select <= s;
        host_command_bus <= d;
        host_cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        host_cs_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task load_mode(input logic [4:0] a, input logic [23:0] w);
        host_byte(3'h0, {3'h0, a});
        host_byte(3'h1, w[23:16]);
        host_byte(3'h1, w[15:8]);
        host_byte(3'h1, w[7:0]);
    endtask
    task pix_case(input logic [4:0] d, input logic [1:0] c, input logic [1:0] u, input logic [23:0] e,
                  input logic [1:0] t);
        @(posedge clk_sys);
        pix_in <= 24'habcdef;
        did_in <= d;
        cur_in <= c;
        pup_in <= u;
        repeat (5) @(posedge clk_sys);
        #1;
        check({8'h0, pix_out}, {8'h0, e});
        check({30'h0, pix_tag}, {30'h0, t});
    endtask
    task vid_case(input logic [4:0] d, input logic x);
        logic [23:0] v;
        @(posedge clk_sys);
        did_in <= d;
        video_key <= 1'b1;
        #1;
        v = vid_in;
        repeat (5) @(posedge clk_sys);
        video_key <= 1'b0;
        #1;
        if (x)
            check({8'h0, pix_out}, {8'h0, v});
        else
            check({8'h0, pix_out}, {8'h0, v[19:16], v[19:16], v[11:8], v[11:8], v[3:0], v[3:0]});
        check({30'h0, pix_tag}, 32'h1);
    endtask
    task settle;
        repeat (10) @(posedge clk_sys);
        #1;
    endtask
    task run_pix;
        repeat (12) begin
            @(posedge clk_sys);
            pix_in <= pix_in + 24'h010307;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task s_regs;
        axi(1'b0, `A_CTRL, 32'h0);
        check(rd_data, {25'h0, `CTRL_RST});
        axi(1'b0, 8'h10, 32'h0);
        check({30'h0, rsp}, {30'h0, `RESP_ERR});
        axi(1'b1, 8'h14, 32'h1);
        check({30'h0, rsp}, {30'h0, `RESP_ERR});
    endtask
    task s_host;
        host_byte(3'h2, 8'ha5);
        host_byte(3'h3, 8'h3c);
        axi(1'b0, `A_CURMAP, 32'h0);
        check(rd_data, 32'ha5);
        axi(1'b0, `A_PMAP, 32'h0);
        check(rd_data, 32'h3c);
        load_mode(5'h3, 24'h000150);
        load_mode(5'h1, 24'h000001);
        load_mode(5'h2, 24'h000005);
        axi(1'b0, `A_STAT, 32'h0);
        check({28'h0, rd_data[5:2]}, 32'h3);
        c_blank_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        axi(1'b0, `A_STAT, 32'h0);
        check({28'h0, rd_data[5:2]}, 32'h0);
        @(posedge clk_sys);
        c_blank_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check({31'h0, quarter_pixel_clock}, 32'h0);
        @(posedge clk_sys);
        #1;
        check({31'h0, quarter_pixel_clock}, 32'h1);
    endtask
    task s_pixels;
        pix_case(5'h3, 2'h0, 2'h0, 24'h0015ef, 2'h0);
        pix_case(5'h1, 2'h0, 2'h0, 24'habcdef, 2'h1);
        pix_case(5'h3, 2'h2, 2'h0, 24'h0014a2, 2'h0);
        axi(1'b1, `A_CTRL, 32'h32);
        pix_case(5'h3, 2'h0, 2'h1, 24'h000781, 2'h0);
        axi(1'b1, `A_CTRL, 32'h61);
        pix_case(5'h2, 2'h0, 2'h0, 24'habcdef, 2'h1);
        vid_case(5'h2, 1'b1);
    endtask
    task s_video;
        #1;
        check({31'h0, vid_oe}, 32'h1);
        run_pix();
        settle();
        check({8'h0, vid_out}, {8'h0, map_rgb});
        axi(1'b1, `A_CTRL, 32'h65);
        aux_in <= 8'hb5;
        #1;
        check({31'h0, vid_alpha}, 32'h1);
        run_pix();
        settle();
        check({8'h0, vid_out}, {8'h0, map_rgb[23:19], 3'h5, map_rgb[15:10], 2'h2, map_rgb[7:3], 3'h5});
        axi(1'b1, `A_CTRL, 32'h6d);
        run_pix();
        settle();
        check({8'h0, vid_out}, {8'h0, map_rgb[23:19], 3'h5, map_rgb[15:10], 2'h3, map_rgb[7:3], 3'h3});
        axi(1'b1, `A_CTRL, 32'h22);
        #1;
        check({31'h0, vid_oe}, 32'h0);
        check({8'h0, vid_out_en}, {8'h0, `SPLIT_OUT});
        vid_case(5'h2, 1'b0);
        run_pix();
        axi(1'b1, `A_CTRL, 32'h00);
        run_pix();
        settle();
        check({8'h0, vid_out}, {8'h0, map_rgb[23:20], 4'h0, map_rgb[15:12], 4'h0, map_rgb[7:4], 4'h0});
    endtask
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        c_blank_n = 1'b1;
        video_key = 1'b0;
        host_cs_n = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {pix_in, aux_in, pup_in, cur_in, did_in} = 41'h0;
        {host_command_bus, host_register_select, awaddr, araddr, wdata} = 59'h0;
        wstrb = 4'hf;
        bad_count = 0;
        checks_done = 0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        s_regs();
        s_host();
        s_pixels();
        s_video();
        give_verdict();
    end
endmodule
`default_nettype wire
